/* File: common/servo_pkg.sv */
// constants for the servo input, brake and supervision parameter block
`default_nettype none
package servo_pkg;
  // -------------------------------------------------------------------
  // parameter sub-indices
  // -------------------------------------------------------------------
  localparam logic [7:0] ADDR_ENTRIES    = 8'h00;
  localparam logic [7:0] ADDR_SEL1       = 8'h01;
  localparam logic [7:0] ADDR_SEL2       = 8'h02;
  localparam logic [7:0] ADDR_SEL3       = 8'h03;
  localparam logic [7:0] ADDR_SEL4       = 8'h04;
  localparam logic [7:0] ADDR_IN_POL     = 8'h05;
  localparam logic [7:0] ADDR_CAP_TIME   = 8'h06;
  localparam logic [7:0] ADDR_BRAKE_SEL  = 8'h07;
  localparam logic [7:0] ADDR_POWER_ON   = 8'h08;
  localparam logic [7:0] ADDR_OUT_POL    = 8'h09;
  localparam logic [7:0] ADDR_VARIANT    = 8'h0A;
  localparam logic [7:0] ADDR_BAND       = 8'h0B;
  localparam logic [7:0] ADDR_STILL      = 8'h0C;
  localparam logic [7:0] ADDR_HOME_SHIFT = 8'h0D;
  localparam logic [7:0] ADDR_PCT        = 8'h0E;
  localparam logic [7:0] ADDR_UNDER      = 8'h0F;
  localparam logic [7:0] ADDR_OVER       = 8'h10;
  // -------------------------------------------------------------------
  // reset values
  // -------------------------------------------------------------------
  localparam logic [7:0]  ENTRY_COUNT    = 8'h03;
  localparam logic [7:0]  RST_SEL1       = 8'h00;
  localparam logic [7:0]  RST_SEL2       = 8'h01;
  localparam logic [7:0]  RST_SEL3       = 8'h02;
  localparam logic [7:0]  RST_SEL4       = 8'h03;
  localparam logic [7:0]  RST_IN_POL     = 8'h00;
  localparam logic [15:0] RST_CAP_TIME   = 16'h01F4;
  localparam logic [7:0]  RST_POWER_ON   = 8'h00;
  localparam logic [7:0]  RST_OUT_POL    = 8'h01;
  // value shown before the strap is caught; arbitrary
  localparam logic [7:0]  RST_VARIANT    = 8'h0E;
  localparam logic [31:0] RST_BAND       = 32'h0000_2710;
  localparam logic [7:0]  RST_PCT        = 8'h64;
  localparam logic [15:0] RST_UNDER      = 16'h00B4;
  localparam logic [15:0] RST_OVER       = 16'h017C;
  // -------------------------------------------------------------------
  // modes, fields and limits
  // -------------------------------------------------------------------
  localparam logic [7:0]  BRAKE_MANUAL   = 8'h00;
  localparam logic [7:0]  BRAKE_AUTO     = 8'h01;
  localparam logic [7:0]  SEL_MAX        = 8'h03;
  localparam int          OUT_BRAKE_BIT  = 0;
  localparam int          OUT_POL_BIT    = 0;
  localparam int          STAT_NEG_LIMIT = 0;
  localparam int          STAT_POS_LIMIT = 1;
  localparam int          STAT_ENABLE    = 3;
  localparam logic [23:0] PCT_FULL       = 24'h000064;
  localparam logic [23:0] MAX_MA_V0      = 24'h0061A8;
  localparam logic [23:0] MAX_MA_V1      = 24'h0032C8;
  localparam logic [1:0]  INIT_LOAD      = 2'h2;
  localparam logic [1:0]  INIT_DONE      = 2'h3;
endpackage : servo_pkg
`default_nettype wire

/* File: hw/servo_io_brake_supervision.sv */
// input mapping, brake output, standstill and limit supervision
// What this block does
// - each input lands on the status bit chosen by its select, 0 to 3
// - polarity bit per input: 0 passes, 1 inverts
// - status bit 0 negative limit, bit 1 positive limit, bit 3 enable
// - brake on output 3; mode 0 manual, mode 1 automatic
// - manual mode: written output object drives output 3
// - manual mode: output 3 loaded at init from power-on value bit 0
// - automatic mode: output object writes refused, power-on value ignored
// - automatic mode: brake set when stage dead, released when live
// - output polarity bit 0 inverts output object bit 0 onto output 3
// - output polarity writes blocked while automatic mode selected
// - moving to still captures position and raises standstill flag
// - leaving tolerance band around captured position clears standstill
// - standstill supervision runs in every operating mode
// - current limit is percent of 25 A or 13 A by variant
// - any phase over limit suspends control until all are at or below it
// - bus under and over thresholds in volts, defaults 180 and 380
// - only bit 0 of the output object is used, rest read zero
`default_nettype none
module servo_io_brake_supervision (
  input  wire logic        I_CLK,
  input  wire logic        I_SRST,
  input  wire logic        I_SDA_REQ,
  input  wire logic        I_SDA_WE,
  input  wire logic [7:0]  I_SDA_ADDR,
  input  wire logic [31:0] I_SDA_WDATA,
  output var  logic [31:0] O_SDA_RDATA,
  output var  logic        O_SDA_ACK,
  output var  logic        O_SDA_ERR,
  input  wire logic        I_OUTOBJ_WR,
  input  wire logic [7:0]  I_OUTOBJ_WDATA,
  output var  logic [7:0]  O_OUTOBJ,
  output var  logic        O_OUTOBJ_ACK,
  output var  logic        O_OUTOBJ_REJ,
  input  wire logic [3:0]  I_DIN,
  input  wire logic        I_BOARD_VARIANT,
  input  wire logic        I_STAGE_LIVE,
  input  wire logic        I_MOTOR_STILL,
  input  wire logic [31:0] I_POS_ACT,
  input  wire logic [15:0] I_PHASE_A,
  input  wire logic [15:0] I_PHASE_B,
  input  wire logic [15:0] I_PHASE_C,
  input  wire logic [15:0] I_BUS_VOLT,
  output var  logic [3:0]  O_DIN_STATUS,
  output var  logic        O_NEG_LIMIT,
  output var  logic        O_POS_LIMIT,
  output var  logic        O_ENABLE,
  output var  logic        O_BRAKE,
  output var  logic        O_STANDSTILL,
  output var  logic        O_CTRL_SUSPEND,
  output var  logic        O_BUS_LOW,
  output var  logic        O_BUS_HIGH
);
  import servo_pkg::*;

  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  typedef struct packed {
    logic [3:0]       din_s1;
    logic [3:0]       din_s2;
    logic             var_s1;
    logic             var_s2;
    logic [1:0]       init_cnt;
    logic [3:0]       din_stat;
    logic [3:0][7:0]  sel;
    logic [7:0]       in_pol;
    logic [15:0]      cap_time;
    logic [7:0]       brake_sel;
    logic [7:0]       pov;
    logic [7:0]       out_pol;
    logic [7:0]       variant;
    logic [31:0]      band;
    logic [31:0]      home;
    logic [7:0]       pct;
    logic [15:0]      under;
    logic [15:0]      over;
    logic [7:0]       out_obj;
    logic             brake;
    logic             still;
    logic             still_prev;
    logic [31:0]      cap_pos;
    logic             suspend;
    logic             bus_low;
    logic             bus_high;
    logic [31:0]      rdata;
    logic             ack;
    logic             err;
    logic             oack;
    logic             orej;
  } state_t;

  state_t s_reg;
  state_t s_next;
  logic   auto_mode;
  logic   still_rise;
  logic   far_off;
  logic   over_any;

  // -------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------
  function automatic state_t reset_state();
    state_t st;
    st = '0;
    st.sel[0]  = RST_SEL1;
    st.sel[1]  = RST_SEL2;
    st.sel[2]  = RST_SEL3;
    st.sel[3]  = RST_SEL4;
    st.in_pol  = RST_IN_POL;
    st.cap_time = RST_CAP_TIME;
    st.brake_sel = BRAKE_MANUAL;
    st.pov     = RST_POWER_ON;
    st.out_pol = RST_OUT_POL;
    st.variant = RST_VARIANT;
    st.band    = RST_BAND;
    st.pct     = RST_PCT;
    st.under   = RST_UNDER;
    st.over    = RST_OVER;
    st.brake   = RST_OUT_POL[OUT_POL_BIT];
    return st;
  endfunction : reset_state

  function automatic logic [3:0] map_inputs(
    input logic [3:0]      raw,
    input logic [3:0][7:0] sel,
    input logic [3:0]      pol
  );
    logic [3:0] m;
    m = '0;
    for (int k = 0; k < 4; k++) begin
      if (raw[k] ^ pol[k]) begin
        m[sel[k][1:0]] = 1'b1;
      end
    end
    return m;
  endfunction : map_inputs

  function automatic logic over_limit(
    input logic [15:0] cur_ma,
    input logic [7:0]  pct,
    input logic        variant
  );
    logic [23:0] lhs;
    logic [23:0] rhs;
    lhs = 24'(cur_ma) * PCT_FULL;
    rhs = 24'(pct) * (variant ? MAX_MA_V1 : MAX_MA_V0);
    return lhs > rhs;
  endfunction : over_limit

  function automatic logic [32:0] pos_dist(
    input logic [31:0] a,
    input logic [31:0] b
  );
    logic signed [32:0] d;
    d = $signed({a[31], a}) - $signed({b[31], b});
    return d[32] ? 33'(-d) : 33'(d);
  endfunction : pos_dist

  function automatic logic is_mapped(input logic [7:0] addr);
    return addr <= ADDR_OVER;
  endfunction : is_mapped

  function automatic logic is_ro(input logic [7:0] addr);
    return addr == ADDR_ENTRIES || addr == ADDR_VARIANT || addr == ADDR_STILL;
  endfunction : is_ro

  function automatic logic [31:0] read_reg(
    input state_t     st,
    input logic [7:0] addr
  );
    logic [31:0] d;
    d = '0;
    case (addr)
      ADDR_ENTRIES:    d = 32'(ENTRY_COUNT);
      ADDR_SEL1:       d = 32'(st.sel[0]);
      ADDR_SEL2:       d = 32'(st.sel[1]);
      ADDR_SEL3:       d = 32'(st.sel[2]);
      ADDR_SEL4:       d = 32'(st.sel[3]);
      ADDR_IN_POL:     d = 32'(st.in_pol);
      ADDR_CAP_TIME:   d = 32'(st.cap_time);
      ADDR_BRAKE_SEL:  d = 32'(st.brake_sel);
      ADDR_POWER_ON:   d = 32'(st.pov);
      ADDR_OUT_POL:    d = 32'(st.out_pol);
      ADDR_VARIANT:    d = 32'(st.variant);
      ADDR_BAND:       d = st.band;
      ADDR_STILL:      d = 32'(st.still);
      ADDR_HOME_SHIFT: d = st.home;
      ADDR_PCT:        d = 32'(st.pct);
      ADDR_UNDER:      d = 32'(st.under);
      ADDR_OVER:       d = 32'(st.over);
      default:         d = '0;
    endcase
    return d;
  endfunction : read_reg

  function automatic logic write_refused(
    input logic [7:0]  addr,
    input logic [31:0] data,
    input logic        auto_on
  );
    logic bad;
    bad = !is_mapped(addr) || is_ro(addr);
    if (addr >= ADDR_SEL1 && addr <= ADDR_SEL4 && data[7:0] > SEL_MAX) begin
      bad = 1'b1;
    end
    if (addr == ADDR_BRAKE_SEL && data[7:0] > BRAKE_AUTO) begin
      bad = 1'b1;
    end
    if (addr == ADDR_OUT_POL && auto_on) begin
      bad = 1'b1;
    end
    return bad;
  endfunction : write_refused

  // -------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------
  assign auto_mode  = s_reg.brake_sel == BRAKE_AUTO;
  assign still_rise = I_MOTOR_STILL && !s_reg.still_prev;
  assign far_off    = pos_dist(I_POS_ACT, s_reg.cap_pos) > {1'b0, s_reg.band};
  assign over_any   = over_limit(I_PHASE_A, s_reg.pct, s_reg.variant[0])
                    | over_limit(I_PHASE_B, s_reg.pct, s_reg.variant[0])
                    | over_limit(I_PHASE_C, s_reg.pct, s_reg.variant[0]);

  always_comb begin
    s_next = s_reg;
    s_next.din_s1 = I_DIN;
    s_next.din_s2 = s_reg.din_s1;
    s_next.var_s1 = I_BOARD_VARIANT;
    s_next.var_s2 = s_reg.var_s1;
    s_next.ack  = 1'b0;
    s_next.err  = 1'b0;
    s_next.oack = 1'b0;
    s_next.orej = 1'b0;

    // input mapping
    s_next.din_stat = map_inputs(s_reg.din_s2, s_reg.sel, s_reg.in_pol[3:0]);

    // parameter access
    if (I_SDA_REQ) begin
      s_next.ack = 1'b1;
      if (!I_SDA_WE) begin
        s_next.rdata = read_reg(s_reg, I_SDA_ADDR);
        s_next.err   = !is_mapped(I_SDA_ADDR);
      end else if (write_refused(I_SDA_ADDR, I_SDA_WDATA, auto_mode)) begin
        s_next.err = 1'b1;
      end else begin
        case (I_SDA_ADDR)
          ADDR_SEL1:       s_next.sel[0] = I_SDA_WDATA[7:0];
          ADDR_SEL2:       s_next.sel[1] = I_SDA_WDATA[7:0];
          ADDR_SEL3:       s_next.sel[2] = I_SDA_WDATA[7:0];
          ADDR_SEL4:       s_next.sel[3] = I_SDA_WDATA[7:0];
          ADDR_IN_POL:     s_next.in_pol = I_SDA_WDATA[7:0];
          ADDR_CAP_TIME:   s_next.cap_time = I_SDA_WDATA[15:0];
          ADDR_BRAKE_SEL:  s_next.brake_sel = I_SDA_WDATA[7:0];
          ADDR_POWER_ON:   s_next.pov = I_SDA_WDATA[7:0];
          ADDR_OUT_POL:    s_next.out_pol = I_SDA_WDATA[7:0];
          ADDR_BAND:       s_next.band = I_SDA_WDATA;
          ADDR_HOME_SHIFT: s_next.home = I_SDA_WDATA;
          ADDR_PCT:        s_next.pct = I_SDA_WDATA[7:0];
          ADDR_UNDER:      s_next.under = I_SDA_WDATA[15:0];
          ADDR_OVER:       s_next.over = I_SDA_WDATA[15:0];
          default:         s_next.err = 1'b1;
        endcase
      end
    end

    // output object
    if (I_OUTOBJ_WR) begin
      s_next.oack = 1'b1;
      if (auto_mode) begin
        s_next.orej = 1'b1;
      end else begin
        s_next.out_obj = {7'h00, I_OUTOBJ_WDATA[OUT_BRAKE_BIT]};
      end
    end

    // power-on load once strap is synchronised
    if (s_reg.init_cnt != INIT_DONE) begin
      s_next.init_cnt = s_reg.init_cnt + 2'h1;
    end
    if (s_reg.init_cnt == INIT_LOAD) begin
      s_next.variant = {7'h00, s_reg.var_s2};
      if (!auto_mode) begin
        s_next.out_obj = {7'h00, s_reg.pov[OUT_BRAKE_BIT]};
      end
    end

    // automatic brake follows the power stage
    if (auto_mode) begin
      s_next.out_obj = {7'h00, !I_STAGE_LIVE};
    end
    s_next.brake = s_next.out_obj[OUT_BRAKE_BIT] ^ s_next.out_pol[OUT_POL_BIT];

    // standstill supervision, never gated by mode
    s_next.still_prev = I_MOTOR_STILL;
    if (still_rise) begin
      s_next.cap_pos = I_POS_ACT;
      s_next.still   = 1'b1;
    end else if (s_reg.still && far_off) begin
      s_next.still = 1'b0;
    end

    // phase current and bus supervision
    s_next.suspend  = over_any;
    s_next.bus_low  = I_BUS_VOLT < s_reg.under;
    s_next.bus_high = I_BUS_VOLT > s_reg.over;
  end

  // -------------------------------------------------------------------
  // registers
  // -------------------------------------------------------------------
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      s_reg <= reset_state();
    end else begin
      s_reg <= s_next;
    end
  end

  assign O_SDA_RDATA    = s_reg.rdata;
  assign O_SDA_ACK      = s_reg.ack;
  assign O_SDA_ERR      = s_reg.err;
  assign O_OUTOBJ       = s_reg.out_obj;
  assign O_OUTOBJ_ACK   = s_reg.oack;
  assign O_OUTOBJ_REJ   = s_reg.orej;
  assign O_DIN_STATUS   = s_reg.din_stat;
  assign O_NEG_LIMIT    = s_reg.din_stat[STAT_NEG_LIMIT];
  assign O_POS_LIMIT    = s_reg.din_stat[STAT_POS_LIMIT];
  assign O_ENABLE       = s_reg.din_stat[STAT_ENABLE];
  assign O_BRAKE        = s_reg.brake;
  assign O_STANDSTILL   = s_reg.still;
  assign O_CTRL_SUSPEND = s_reg.suspend;
  assign O_BUS_LOW      = s_reg.bus_low;
  assign O_BUS_HIGH     = s_reg.bus_high;

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_SRST);

  din_map_a: assert property (
    (s_reg.din_s2[0] ^ s_reg.in_pol[0]) |=> O_DIN_STATUS[$past(s_reg.sel[0][1:0])]
  ) else $error("input 1 not on its selected bit");

  din_pol_a: assert property (
    (s_reg.in_pol[3:0] == 4'h0 && s_reg.din_s2 == 4'h0) |=> O_DIN_STATUS == 4'h0
  ) else $error("inactive inputs set a status bit");

  auto_brake_a: assert property (
    (auto_mode && !I_SRST) |=> O_OUTOBJ[0] == !$past(I_STAGE_LIVE)
  ) else $error("automatic brake does not follow stage");

  auto_reject_a: assert property (
    (auto_mode && I_OUTOBJ_WR) |=> O_OUTOBJ_REJ && O_OUTOBJ_ACK
  ) else $error("output object write taken in automatic mode");

  manual_write_a: assert property (
    (!auto_mode && I_OUTOBJ_WR && s_reg.init_cnt == INIT_DONE)
      |=> O_OUTOBJ[0] == $past(I_OUTOBJ_WDATA[0]) && !O_OUTOBJ_REJ
  ) else $error("manual output write lost");

  brake_pol_a: assert property (
    (!auto_mode && I_OUTOBJ_WR && s_reg.init_cnt == INIT_DONE
      && !(I_SDA_REQ && I_SDA_WE && I_SDA_ADDR == ADDR_OUT_POL))
      |=> O_BRAKE == ($past(I_OUTOBJ_WDATA[0]) ^ $past(s_reg.out_pol[0]))
  ) else $error("brake pin polarity wrong");

  pol_block_a: assert property (
    (auto_mode && I_SDA_REQ && I_SDA_WE && I_SDA_ADDR == ADDR_OUT_POL)
      |=> O_SDA_ERR && s_reg.out_pol == $past(s_reg.out_pol)
  ) else $error("output polarity changed in automatic mode");

  still_cap_a: assert property (
    still_rise |=> O_STANDSTILL && s_reg.cap_pos == $past(I_POS_ACT)
  ) else $error("standstill capture missed");

  still_leave_a: assert property (
    (s_reg.still && far_off && !still_rise) |=> !O_STANDSTILL
  ) else $error("standstill kept outside band");

  power_on_a: assert property (
    (s_reg.init_cnt == INIT_LOAD && !auto_mode)
      |=> O_OUTOBJ[0] == $past(s_reg.pov[0])
  ) else $error("power-on value not loaded");

  cur_limit_a: assert property (
    over_any |=> O_CTRL_SUSPEND ##1 (O_CTRL_SUSPEND == $past(over_any))
  ) else $error("current limit suspend wrong");

endmodule : servo_io_brake_supervision
`default_nettype wire

/* File: test/param_master.sv */
// fieldbus master model issuing parameter and output-object accesses
`default_nettype none
module param_master (
  input  wire logic        i_clk,
  input  wire logic [31:0] i_rdata,
  input  wire logic        i_ack,
  input  wire logic        i_err,
  input  wire logic        i_obj_ack,
  input  wire logic        i_obj_rej,
  output var  logic        o_req,
  output var  logic        o_we,
  output var  logic [7:0]  o_addr,
  output var  logic [31:0] o_wdata,
  output var  logic        o_obj_wr,
  output var  logic [7:0]  o_obj_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_req      = 1'h0;
    o_we       = 1'h0;
    o_addr     = 8'hFF;
    o_wdata    = 32'h0;
    o_obj_wr   = 1'h0;
    o_obj_data = 8'h0;
  end
  // ------------------------------------------------------------
  // one pulse per access; gap idles first to act slowly
  // ------------------------------------------------------------
  task automatic sda(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input int gap, output logic ok, output logic [31:0] rd,
                     output logic er);
    repeat (gap) @(posedge i_clk);
    @(posedge i_clk);
    o_req   <= 1'h1;
    o_we    <= w;
    o_addr  <= a;
    o_wdata <= d;
    @(posedge i_clk);
    o_req   <= 1'h0;
    o_addr  <= ~a;
    o_wdata <= ~d;
    #1;
    ok = i_ack;
    rd = i_rdata;
    er = i_err;
  endtask : sda
  task automatic obj_wr(input logic [7:0] d, output logic ok, output logic rj);
    @(posedge i_clk);
    o_obj_wr   <= 1'h1;
    o_obj_data <= d;
    @(posedge i_clk);
    o_obj_wr   <= 1'h0;
    o_obj_data <= ~d;
    #1;
    ok = i_obj_ack;
    rj = i_obj_rej;
  endtask : obj_wr
endmodule : param_master
`default_nettype wire

/* File: test/tb_servo_io_brake_supervision.sv */
// self-checking bench for the servo input, brake and supervision block
`default_nettype none
module tb_servo_io_brake_supervision;
  timeunit 1ns;
  timeprecision 1ps;
  import servo_pkg::*;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] v; logic xe;} acc_t;
  typedef struct packed {logic s; logic [31:0] p; logic x;} still_t;
  typedef struct packed {logic [15:0] a, b, c, u; logic [2:0] x;} lim_t;
  localparam logic [3:0] IPOL = 4'h5;
  logic        clk, srst, req, we, owr, ack, err, oack, orej, var_s, live, still;
  logic        nlim, plim, ena, brk, stst, susp, blo, bhi, ok, e, pl;
  logic [7:0]  addr, odat, obj;
  logic [15:0] pa, pb, pc, volt;
  logic [31:0] wd, rdat, r, pos;
  logic [3:0]  din, stat, x;
  int          miscompares = 0;
  int          n_compared = 0;
  acc_t        rows[34] = '{
    '{1'h0,8'h11,32'h0,1'h1}, '{1'h1,8'h00,32'h5,1'h1}, '{1'h1,8'h0A,32'h1,1'h1},
    '{1'h1,8'h0C,32'h1,1'h1}, '{1'h1,8'h01,32'h4,1'h1}, '{1'h1,8'h07,32'h2,1'h1},
    '{1'h0,8'h00,32'h3,1'h0}, '{1'h0,8'h01,32'h0,1'h0}, '{1'h0,8'h02,32'h1,1'h0},
    '{1'h0,8'h03,32'h2,1'h0}, '{1'h0,8'h04,32'h3,1'h0}, '{1'h0,8'h05,32'h0,1'h0},
    '{1'h0,8'h06,32'h1F4,1'h0}, '{1'h0,8'h07,32'h0,1'h0}, '{1'h0,8'h08,32'h0,1'h0},
    '{1'h0,8'h09,32'h1,1'h0}, '{1'h0,8'h0B,32'h2710,1'h0}, '{1'h0,8'h0C,32'h0,1'h0},
    '{1'h0,8'h0D,32'h0,1'h0}, '{1'h0,8'h0E,32'h64,1'h0}, '{1'h0,8'h0F,32'hB4,1'h0},
    '{1'h0,8'h10,32'h17C,1'h0}, '{1'h1,8'h01,32'h3,1'h0}, '{1'h1,8'h02,32'h2,1'h0},
    '{1'h1,8'h03,32'h1,1'h0}, '{1'h1,8'h04,32'h0,1'h0}, '{1'h1,8'h05,32'h5,1'h0},
    '{1'h1,8'h0B,32'hA,1'h0}, '{1'h1,8'h0E,32'h32,1'h0}, '{1'h0,8'h01,32'h3,1'h0},
    '{1'h0,8'h04,32'h0,1'h0}, '{1'h0,8'h05,32'h5,1'h0}, '{1'h0,8'h0B,32'hA,1'h0},
    '{1'h0,8'h0E,32'h32,1'h0}
  };
  still_t      srow[8] = '{
    '{1'h0,32'h64,1'h0}, '{1'h1,32'h64,1'h1}, '{1'h1,32'h6E,1'h1}, '{1'h1,32'h6F,1'h0},
    '{1'h1,32'h64,1'h0}, '{1'h0,32'h64,1'h0}, '{1'h1,32'h64,1'h1}, '{1'h1,32'h59,1'h0}
  };
  lim_t        lrow[6] = '{
    '{16'h30D4,16'h0,16'h0,16'hC8,3'h0}, '{16'h0,16'h30D5,16'h0,16'hC8,3'h4},
    '{16'h0,16'h0,16'h30D5,16'hB3,3'h6}, '{16'h2EE0,16'h0,16'h0,16'hB4,3'h0},
    '{16'h0,16'h0,16'h0,16'h17D,3'h1}, '{16'h0,16'h0,16'h0,16'h17C,3'h0}
  };
  servo_io_brake_supervision dut (
    .I_CLK(clk), .I_SRST(srst), .I_SDA_REQ(req), .I_SDA_WE(we), .I_SDA_ADDR(addr),
    .I_SDA_WDATA(wd), .O_SDA_RDATA(rdat), .O_SDA_ACK(ack), .O_SDA_ERR(err),
    .I_OUTOBJ_WR(owr), .I_OUTOBJ_WDATA(odat), .O_OUTOBJ(obj), .O_OUTOBJ_ACK(oack),
    .O_OUTOBJ_REJ(orej), .I_DIN(din), .I_BOARD_VARIANT(var_s), .I_STAGE_LIVE(live),
    .I_MOTOR_STILL(still), .I_POS_ACT(pos), .I_PHASE_A(pa), .I_PHASE_B(pb),
    .I_PHASE_C(pc), .I_BUS_VOLT(volt), .O_DIN_STATUS(stat), .O_NEG_LIMIT(nlim),
    .O_POS_LIMIT(plim), .O_ENABLE(ena), .O_BRAKE(brk), .O_STANDSTILL(stst),
    .O_CTRL_SUSPEND(susp), .O_BUS_LOW(blo), .O_BUS_HIGH(bhi)
  );
  param_master u_m (
    .i_clk(clk), .i_rdata(rdat), .i_ack(ack), .i_err(err), .i_obj_ack(oack),
    .i_obj_rej(orej), .o_req(req), .o_we(we), .o_addr(addr), .o_wdata(wd),
    .o_obj_wr(owr), .o_obj_data(odat)
  );
  // ------------------------------------------------------------
  // checking and access helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic results;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] v,
                     input logic xe);
    u_m.sda(w, a, v, 0, ok, r, e);
    chk({ok, e}, {1'h1, xe});
  endtask : acc
  task automatic bw(input logic [7:0] d);
    u_m.obj_wr(d, ok, e);
    chk({ok, e, obj}, {2'h2, 7'h0, d[0]});
    chk(brk, d[0] ^ pl);
  endtask : bw
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  initial begin
    #100000;
    miscompares++;
    results();
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    srst  = 1'h1;
    var_s = 1'h0;
    live  = 1'h0;
    still = 1'h0;
    pos   = 32'h0;
    din   = 4'h0;
    pa    = 16'h0;
    pb    = 16'h0;
    pc    = 16'h0;
    volt  = 16'hC8;
    pl    = 1'h1;
    repeat (2) @(posedge clk);
    srst <= 1'h0;
    repeat (6) @(posedge clk);
    #1;
    chk({obj, brk}, 9'h1);
    $display("reset test done");
    foreach (rows[i]) begin
      u_m.sda(rows[i].w, rows[i].a, rows[i].v, i % 2, ok, r, e);
      chk({ok, e}, {1'h1, rows[i].xe});
      if (!rows[i].w && !rows[i].xe) chk(r, rows[i].v);
    end
    $display("register table test done");
    for (int v = 0; v < 16; v++) begin
      @(posedge clk);
      din <= v[3:0];
      repeat (4) @(posedge clk);
      #1;
      for (int k = 0; k < 4; k++) x[3 - k] = v[k] ^ IPOL[k];
      chk(stat, x);
      chk({ena, plim, nlim}, {x[3], x[1], x[0]});
    end
    $display("input mapping test done");
    bw(8'h01);
    bw(8'hFE);
    acc(1'h1, ADDR_OUT_POL, 32'h0, 1'h0);
    pl = 1'h0;
    bw(8'h01);
    bw(8'h00);
    acc(1'h1, ADDR_BRAKE_SEL, {24'h0, BRAKE_AUTO}, 1'h0);
    u_m.obj_wr(8'h01, ok, e);
    chk({ok, e}, 2'h3);
    acc(1'h1, ADDR_OUT_POL, 32'h1, 1'h1);
    acc(1'h0, ADDR_OUT_POL, 32'h0, 1'h0);
    chk(r, 32'h0);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      live <= k[0];
      repeat (3) @(posedge clk);
      #1;
      chk({obj, brk}, {7'h0, ~k[0], ~k[0]});
    end
    acc(1'h1, ADDR_BRAKE_SEL, {24'h0, BRAKE_MANUAL}, 1'h0);
    $display("brake test done");
    foreach (srow[i]) begin
      @(posedge clk);
      still <= srow[i].s;
      pos   <= srow[i].p;
      repeat (3) @(posedge clk);
      acc(1'h0, ADDR_STILL, 32'h0, 1'h0);
      chk(stst, srow[i].x);
      chk(r, {31'h0, srow[i].x});
    end
    $display("standstill test done");
    foreach (lrow[i]) begin
      @(posedge clk);
      pa   <= lrow[i].a;
      pb   <= lrow[i].b;
      pc   <= lrow[i].c;
      volt <= lrow[i].u;
      repeat (3) @(posedge clk);
      #1;
      chk({susp, blo, bhi}, lrow[i].x);
    end
    $display("limit test done");
    @(posedge clk);
    srst  <= 1'h1;
    var_s <= 1'h1;
    pa    <= 16'h32C9;
    repeat (2) @(posedge clk);
    srst <= 1'h0;
    acc(1'h1, ADDR_POWER_ON, 32'h1, 1'h0);
    acc(1'h0, ADDR_BAND, 32'h0, 1'h0);
    chk(r, 32'h2710);
    chk({susp, obj, brk}, 10'h202);
    @(posedge clk);
    pa <= 16'h32C8;
    repeat (3) @(posedge clk);
    #1;
    chk(susp, 1'h0);
    $display("second reset test done");
    results();
  end
endmodule : tb_servo_io_brake_supervision
`default_nettype wire
